// ==== shared/cdto_pkg.sv ====
package cdto_pkg;

	localparam int NUM_PARAMS = 7;
	localparam int VAL_W      = 7;
	localparam int DATA_W     = 8;
	localparam int ADDR_W     = 8;
	localparam int OV_BIT     = 7;
	localparam int NUM_RATES  = 4;

	typedef logic [VAL_W-1:0]  cdto_val_t;
	typedef logic [DATA_W-1:0] cdto_data_t;
	typedef logic [ADDR_W-1:0] cdto_addr_t;

	localparam cdto_addr_t PAGE_TIMING = 8'h00;
	localparam cdto_addr_t ADDR_SPARE  = 8'h1F;

	// order: clk prepare, zero, trail, post; data prepare, zero, trail
	localparam cdto_addr_t ADDR_TIMING [NUM_PARAMS] = '{
		8'h40, 8'h41, 8'h42, 8'h43, 8'h44, 8'h45, 8'h46
	};

	localparam cdto_data_t SPARE_RST = 8'h00;
	localparam cdto_val_t  VAL_RST   = 7'h00;
	localparam logic       OV_RST    = 1'b0;
	localparam cdto_data_t RDATA_IDLE = 8'h00;

	typedef enum logic [1:0] {
		CDTO_RATE_400  = 2'h0,
		CDTO_RATE_800  = 2'h1,
		CDTO_RATE_1500 = 2'h2,
		CDTO_RATE_1600 = 2'h3
	} cdto_rate_t;

	// derived timing per lane rate, in byte clock cycles
	localparam cdto_val_t AUTO_TABLE [NUM_RATES][NUM_PARAMS] = '{
		'{7'h02, 7'h0C, 7'h03, 7'h07, 7'h02, 7'h04, 7'h03},
		'{7'h04, 7'h18, 7'h05, 7'h0B, 7'h04, 7'h07, 7'h05},
		'{7'h07, 7'h2D, 7'h09, 7'h13, 7'h07, 7'h0D, 7'h09},
		'{7'h08, 7'h30, 7'h0A, 7'h14, 7'h08, 7'h0E, 7'h0A}
	};

	typedef struct packed {
		cdto_addr_t page;
		cdto_addr_t addr;
		cdto_data_t wdata;
		logic       wr;
		logic       rd;
	} cdto_req_t;

endpackage : cdto_pkg

// ==== verilog/cdto_regs.sv ====
// Operation
// - reg 0x40 bit7 selects clock prepare source
// - reg 0x41 bit7 selects clock zero source
// - reg 0x42 bit7 selects clock trail source
// - reg 0x43 bit7 selects clock post; zero reset
// - reg 0x44 bit7 selects data prepare source
// - reg 0x45 bit7 selects data zero source
// - reg 0x46 bit7 selects data trail source
// - override clear: value read-only, shows automatic value
// - override set: value read/write, drives timing
// - reg 0x1F spare read/write byte, reset zero
//
// Design decision made here: strobed register access.
`timescale 1ns/10ps
`default_nettype none

module cdto_regs
	import cdto_pkg::*;
(
	input  wire logic                         clock,
	input  wire logic                         rst,
	input  wire cdto_req_t                    bus_req,
	input  wire cdto_rate_t                   lane_rate,
	output var  cdto_data_t                   rdata,
	output var  logic      [NUM_PARAMS-1:0]   timing_override,
	output var  cdto_val_t [NUM_PARAMS-1:0]   timing_value
);

	logic                    page_ok;
	logic      [NUM_PARAMS-1:0] ov;
	logic      [NUM_PARAMS-1:0] next_ov;
	cdto_val_t [NUM_PARAMS-1:0] sw;
	cdto_val_t [NUM_PARAMS-1:0] next_sw;
	cdto_val_t [NUM_PARAMS-1:0] auto_val;
	cdto_val_t [NUM_PARAMS-1:0] eff_val;
	cdto_val_t [NUM_PARAMS-1:0] next_timing_value;
	logic      [NUM_PARAMS-1:0] next_timing_override;
	cdto_data_t              spare;
	cdto_data_t              next_spare;
	cdto_data_t              next_rdata;

	assign page_ok = (bus_req.page == PAGE_TIMING);

	// one override bit and one software value per timing parameter
	for (genvar i = 0; i < NUM_PARAMS; i++) begin : g_param
		logic hit;

		always_comb begin
			hit         = bus_req.wr && page_ok && (bus_req.addr == ADDR_TIMING[i]);
			auto_val[i] = AUTO_TABLE[lane_rate][i];
			next_ov[i]  = ov[i];
			next_sw[i]  = sw[i];
			if (hit) begin
				next_ov[i] = bus_req.wdata[OV_BIT];
			end
			if (hit && bus_req.wdata[OV_BIT]) begin
				next_sw[i] = bus_req.wdata[VAL_W-1:0];
			end else if (!ov[i]) begin
				// value ignores writes and follows the derived figure
				next_sw[i] = auto_val[i];
			end
			eff_val[i]              = ov[i] ? sw[i] : auto_val[i];
			next_timing_value[i]    = eff_val[i];
			next_timing_override[i] = ov[i];
		end

		always_ff @(posedge clock or posedge rst) begin
			if (rst) begin
				ov[i] <= OV_RST;
				sw[i] <= VAL_RST;
			end else begin
				ov[i] <= next_ov[i];
				sw[i] <= next_sw[i];
			end
		end
	end

	always_comb begin
		next_spare = spare;
		if (bus_req.wr && page_ok && (bus_req.addr == ADDR_SPARE)) begin
			next_spare = bus_req.wdata;
		end
	end

	// read data stands only in the cycle after the read strobe
	always_comb begin
		next_rdata = RDATA_IDLE;
		if (bus_req.rd && page_ok) begin
			if (bus_req.addr == ADDR_SPARE) begin
				next_rdata = spare;
			end
			for (int k = 0; k < NUM_PARAMS; k++) begin
				if (bus_req.addr == ADDR_TIMING[k]) begin
					next_rdata = {ov[k], eff_val[k]};
				end
			end
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			spare           <= SPARE_RST;
			rdata           <= RDATA_IDLE;
			timing_override <= '0;
			timing_value    <= '0;
		end else begin
			spare           <= next_spare;
			rdata           <= next_rdata;
			timing_override <= next_timing_override;
			timing_value    <= next_timing_value;
		end
	end

endmodule : cdto_regs

`default_nettype wire

// ==== verification/cdto_regs_asserts.sv ====
`timescale 1ns/10ps
`default_nettype none
module cdto_regs_asserts
	import cdto_pkg::*;
(
	input wire logic                       clock,
	input wire logic                       rst,
	input wire cdto_req_t                  bus_req,
	input wire cdto_rate_t                 lane_rate,
	input wire cdto_data_t                 rdata,
	input wire logic [NUM_PARAMS-1:0]      timing_override,
	input wire cdto_val_t [NUM_PARAMS-1:0] timing_value
);
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	wire logic w = bus_req.wr && bus_req.page == 8'h00;
	a_rdata_idle: assert property (!$past(bus_req.rd) |-> rdata == 8'h00)
		else $error("rdata not idle");
	a_reset_clear: assert property ($past(rst) |-> timing_override == 7'h00)
		else $error("override set after reset");
	a_ovr_hold: assert property (!$past(bus_req.wr) && !$past(bus_req.wr, 2)
		|-> $stable(timing_override)) else $error("override moved");
	a_page_refused: assert property (bus_req.wr && bus_req.page != 8'h00
		&& !$past(bus_req.wr) |=> ##1 $stable(timing_override)) else $error("page ignored");
	for (genvar i = 0; i < NUM_PARAMS; i++) begin : g_p
		a_ovr_write: assert property (w && bus_req.addr == ADDR_TIMING[i]
			|=> ##1 timing_override[i] == $past(bus_req.wdata[7], 2)) else $error("ov bit");
		a_sw_value: assert property (w && bus_req.addr == ADDR_TIMING[i] && bus_req.wdata[7]
			|=> ##1 timing_value[i] == $past(bus_req.wdata[6:0], 2)) else $error("sw value");
		a_auto_track: assert property (!timing_override[i] && !$past(rst)
			&& $stable(lane_rate) && lane_rate == $past(lane_rate, 2)
			|-> timing_value[i] == AUTO_TABLE[lane_rate][i]) else $error("auto value");
		a_read_back: assert property (bus_req.rd && !bus_req.page && bus_req.addr == ADDR_TIMING[i]
			|=> rdata == {timing_override[i], timing_value[i]}) else $error("read back");
	end
endmodule : cdto_regs_asserts
`default_nettype wire

// ==== verification/cdto_regs_tb.sv ====
`timescale 1ns/10ps
`default_nettype none
module cdto_regs_tb;
	import cdto_pkg::*;
	logic clock = 0, rst = 1;
	cdto_req_t req = '0;
	cdto_rate_t rate = CDTO_RATE_400;
	cdto_data_t rdata, v;
	cdto_addr_t a;
	logic [6:0] ov;
	cdto_val_t [6:0] tv;
	int fail_count = 0, total_checks = 0;
	always #4 clock = ~clock;
	cdto_regs u_dut (.clock(clock), .rst(rst), .bus_req(req), .lane_rate(rate), .rdata(rdata),
		.timing_override(ov), .timing_value(tv));
	task automatic chk(cdto_data_t s, cdto_data_t e);
		total_checks++;
		if (s !== e) begin
			fail_count++;
			$display("BAD t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask : chk
	task automatic wr(cdto_addr_t p, cdto_addr_t ad, cdto_data_t d);
		req <= '{p, ad, d, 1'b1, 1'b0};
		@(posedge clock);
		req.wr <= 1'b0;
		@(posedge clock);
	endtask : wr
	task automatic rd(cdto_addr_t p, cdto_addr_t ad, cdto_data_t e);
		req <= '{p, ad, 8'h00, 1'b0, 1'b1};
		@(posedge clock);
		req.rd <= 1'b0;
		#1 chk(rdata, e);
		@(posedge clock);
	endtask : rd
	task automatic conclude;
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : conclude
	initial begin
		#100000;
		fail_count++;
		conclude();
	end
	initial begin
		repeat (10) @(posedge clock);
		rst <= 1'b0;
		repeat (2) @(posedge clock);
		rd(8'h00, 8'h1F, 8'h00);
		wr(8'h00, 8'h1F, 8'hA5);
		rd(8'h00, 8'h1F, 8'hA5);
		rd(8'h01, 8'h1F, 8'h00);
		for (int r = 0; r < NUM_RATES; r++) begin
			rate <= cdto_rate_t'(r);
			repeat (3) @(posedge clock);
			for (int i = 0; i < NUM_PARAMS; i++) begin
				a = ADDR_TIMING[i];
				v = {1'b0, AUTO_TABLE[r][i]};
				rd(8'h00, a, v);
				wr(8'h00, a, 8'h15);
				rd(8'h00, a, v);
				wr(8'h00, a, 8'(8'hB0 + i));
				wr(8'h01, a, 8'h00);
				rd(8'h00, a, 8'(8'hB0 + i));
				chk({ov[i], tv[i]}, 8'(8'hB0 + i));
				wr(8'h00, a, 8'h00);
				rd(8'h00, a, v);
			end
		end
		conclude();
	end
endmodule : cdto_regs_tb
bind cdto_regs cdto_regs_asserts u_chk (.clock(clock), .rst(rst), .bus_req(bus_req),
	.lane_rate(lane_rate), .rdata(rdata), .timing_override(timing_override),
	.timing_value(timing_value));
`default_nettype wire
